// ### dlc_display_list_coprocessor.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module dlc_display_list_coprocessor
	import dlc_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Instruction memory
	output logic             mem_req,
	output logic [17:0]      mem_addr,
	input  wire logic        mem_ack,
	input  wire logic [15:0] mem_rdata,
	// Register bus
	output logic             register_bus_valid,
	output logic [8:0]       register_bus_addr,
	output logic [15:0]      register_bus_data,
	// Beam and blitter
	input  wire logic [8:0]  beam_row,
	input  wire logic [8:0]  beam_col,
	input  wire logic        vblank_start,
	input  wire logic        blit_done,
	input  wire logic        blit_busy,
	input  wire logic        blit_zero,
	// Arbitration
	input  wire logic        blit_req,
	input  wire logic        cpu_req,
	output logic             blit_grant,
	output logic             cpu_grant,
	output logic             bus_steal_enable,
	output logic [8:0]       channel_enable
);

	localparam int unsigned SLOT_W = $clog2(MEM_CYCLE_CLKS);

	dlc_state_t            state;
	logic [SLOT_W-1:0]     slot_cnt;
	logic                  slot_start;
	logic                  slot_odd;
	logic [PTR_BITS-1:0]   pc;
	logic [PTR_BITS-1:0]   ptr_one;
	logic [PTR_BITS-1:0]   ptr_two;
	logic [15:0]           first_instr_word;
	logic [15:0]           second_instr_word;
	logic                  pending;
	logic                  skip_next;
	logic [10:0]           dma_ctrl;
	logic                  danger;
	logic [9:0]            apb_idx;
	logic                  apb_mapped;
	logic                  apb_wr;
	logic                  ack_ok;
	logic                  is_move;
	logic [9:0]            cop_idx;
	logic                  move_ok;
	logic                  cop_wr;
	logic                  wr_en;
	logic [9:0]            wr_idx;
	logic [15:0]           wr_data;
	logic                  jump_one;
	logic                  jump_two;
	logic                  fetch_en;
	logic                  issue;

	function automatic logic in_blit_range(input logic [9:0] idx);
		return idx >= IDX_BLIT_REG_FIRST && idx <= IDX_BLIT_REG_LAST;
	endfunction

	function automatic logic beam_reached(input logic [15:0] w1, input logic [15:0] w2,
			input logic [8:0] row, input logic [8:0] col, input logic done);
		logic [14:0] beam;
		logic [14:0] pos;
		logic [14:0] mask;
		beam = {row[7:0], col[8:2]};
		pos  = {w1[15:8], w1[7:1]};
		mask = {1'b1, w2[14:8], w2[7:1]};
		return ((beam & mask) >= (pos & mask)) && (w2[BLIT_DONE_IGN_BIT] || done);
	endfunction

	// Memory cycle divider; parity marks the slots the coprocessor may use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_cnt   <= '0;
			slot_start <= 1'b0;
			slot_odd   <= 1'b0;
		end else if (slot_cnt == SLOT_W'(MEM_CYCLE_CLKS - 1)) begin
			slot_cnt   <= '0;
			slot_start <= 1'b1;
			slot_odd   <= ~slot_odd;
		end else begin
			slot_cnt   <= slot_cnt + 1'b1;
			slot_start <= 1'b0;
		end
	end

	// Shared write path: APB wins, so a coprocessor move in the same cycle misses the local registers but still reaches the register bus
	assign apb_idx    = paddr[11:2];
	assign apb_mapped = paddr[1:0] == 2'b00 && (apb_idx == IDX_DMA_CONTROL_READ ||
		apb_idx == IDX_COPROC_CONTROL || apb_idx == IDX_JUMP_PTR_ONE_HIGH ||
		apb_idx == IDX_JUMP_PTR_ONE_LOW || apb_idx == IDX_JUMP_PTR_TWO_HIGH ||
		apb_idx == IDX_JUMP_PTR_TWO_LOW || apb_idx == IDX_JUMP_STROBE_ONE ||
		apb_idx == IDX_JUMP_STROBE_TWO || apb_idx == IDX_FETCH_MARKER ||
		apb_idx == IDX_DMA_CONTROL_WRITE);
	assign apb_wr  = psel && penable && pready && pwrite && apb_mapped;
	assign ack_ok  = mem_ack && pending;
	assign is_move = !first_instr_word[INSTR_CLASS_BIT];
	assign cop_idx = {1'b0, first_instr_word[8:1], 1'b0};
	assign move_ok = !skip_next && (danger || !in_blit_range(cop_idx));
	assign cop_wr  = ack_ok && state == ST_FETCH_SECOND && is_move && move_ok;
	assign wr_en   = apb_wr || cop_wr;
	assign wr_idx  = apb_wr ? apb_idx : cop_idx;
	assign wr_data = apb_wr ? pwdata[15:0] : mem_rdata;

	// Blanking takes precedence over either strobe
	assign jump_one = vblank_start || (wr_en && wr_idx == IDX_JUMP_STROBE_ONE);
	assign jump_two = !vblank_start && wr_en && wr_idx == IDX_JUMP_STROBE_TWO;

	assign fetch_en = dma_ctrl[MASTER_ENABLE_BIT] && dma_ctrl[COPROC_ENABLE_BIT];
	assign issue    = slot_start && slot_odd && fetch_en && state != ST_BEAM_WAIT &&
		!pending && !jump_one && !jump_two;

	// APB answers in the access phase after every setup; no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !apb_mapped;
			if (psel && !penable && !pwrite && apb_idx == IDX_DMA_CONTROL_READ && apb_mapped) begin
				prdata <= {16'h0000, 1'b0, blit_busy, blit_zero, 2'b00, dma_ctrl};
			end else begin
				prdata <= '0;
			end
		end
	end

	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_ctrl <= DMA_CONTROL_RESET;
			danger   <= DANGER_MODE_RESET;
		end else if (wr_en) begin
			if (wr_idx == IDX_DMA_CONTROL_WRITE) begin
				if (wr_data[SET_OR_CLEAR_BIT]) begin
					dma_ctrl <= dma_ctrl | wr_data[10:0];
				end else begin
					dma_ctrl <= dma_ctrl & ~wr_data[10:0];
				end
			end
			if (wr_idx == IDX_COPROC_CONTROL) begin
				danger <= wr_data[DANGER_MODE_BIT];
			end
		end
	end

	// Jump pointers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_one <= '0;
			ptr_two <= '0;
		end else if (wr_en) begin
			case (wr_idx)
				IDX_JUMP_PTR_ONE_HIGH: ptr_one[PTR_BITS-1:PTR_LO_BITS] <= wr_data[PTR_HI_BITS-1:0];
				IDX_JUMP_PTR_ONE_LOW:  ptr_one[PTR_LO_BITS-1:0] <= wr_data[PTR_LO_BITS-1:0];
				IDX_JUMP_PTR_TWO_HIGH: ptr_two[PTR_BITS-1:PTR_LO_BITS] <= wr_data[PTR_HI_BITS-1:0];
				IDX_JUMP_PTR_TWO_LOW:  ptr_two[PTR_LO_BITS-1:0] <= wr_data[PTR_LO_BITS-1:0];
				default: ;
			endcase
		end
	end

	// Sequencer; a jump drops any fetch in flight and ignores its late answer; a move answer arriving in the jump cycle still reaches the register bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state              <= ST_FETCH_FIRST;
			pc                 <= '0;
			first_instr_word   <= '0;
			second_instr_word  <= '0;
			pending            <= 1'b0;
			skip_next          <= 1'b0;
			mem_req            <= 1'b0;
			mem_addr           <= '0;
			register_bus_valid <= 1'b0;
			register_bus_addr  <= '0;
			register_bus_data  <= '0;
		end else begin
			mem_req            <= issue;
			register_bus_valid <= 1'b0;
			if (issue) begin
				mem_addr <= pc;
				pending  <= 1'b1;
			end
			if (jump_one || jump_two) begin
				pc        <= jump_one ? ptr_one : ptr_two;
				state     <= ST_FETCH_FIRST;
				pending   <= 1'b0;
				skip_next <= 1'b0;
				if (cop_wr) begin
					register_bus_valid <= 1'b1;
					register_bus_addr  <= cop_idx[8:0];
					register_bus_data  <= mem_rdata;
				end
			end else if (ack_ok) begin
				pc      <= pc + 18'd1;
				pending <= 1'b0;
				case (state)
					ST_FETCH_FIRST: begin
						first_instr_word   <= mem_rdata;
						state              <= ST_FETCH_SECOND;
						register_bus_valid <= 1'b1;
						register_bus_addr  <= IDX_FETCH_MARKER[8:0];
						register_bus_data  <= mem_rdata;
					end
					ST_FETCH_SECOND: begin
						state             <= ST_FETCH_FIRST;
						skip_next         <= 1'b0;
						register_bus_data <= mem_rdata;
						if (is_move) begin
							register_bus_valid <= move_ok;
							register_bus_addr  <= cop_idx[8:0];
						end else begin
							second_instr_word  <= mem_rdata;
							register_bus_valid <= 1'b1;
							register_bus_addr  <= IDX_FETCH_MARKER[8:0];
							if (!mem_rdata[INSTR_CLASS_BIT]) begin
								state <= ST_BEAM_WAIT;
							end else begin
								skip_next <= beam_reached(first_instr_word, mem_rdata, beam_row,
									beam_col, blit_done);
							end
						end
					end
					default: state <= ST_FETCH_FIRST;
				endcase
			end else if (state == ST_BEAM_WAIT && beam_reached(first_instr_word,
					second_instr_word, beam_row, beam_col, blit_done)) begin
				state <= ST_FETCH_FIRST;
			end
		end
	end

	// Slot arbitration on every slot start; an odd-slot coprocessor fetch takes the slot from blitter and CPU
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blit_grant <= 1'b0;
			cpu_grant  <= 1'b0;
		end else if (slot_start) begin
			if (issue) begin
				blit_grant <= 1'b0;
				cpu_grant  <= 1'b0;
			end else if (blit_req && dma_ctrl[MASTER_ENABLE_BIT] && dma_ctrl[BLIT_ENABLE_BIT] &&
					(dma_ctrl[BLIT_PRIORITY_BIT] || !cpu_req)) begin
				blit_grant <= 1'b1;
				cpu_grant  <= 1'b0;
			end else begin
				blit_grant <= 1'b0;
				cpu_grant  <= cpu_req && !(dma_ctrl[BLIT_PRIORITY_BIT] && blit_busy);
			end
		end
	end

	// Registered enables for the other channels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_steal_enable <= 1'b1;
			channel_enable   <= '0;
		end else begin
			bus_steal_enable <= !(dma_ctrl[BLIT_PRIORITY_BIT] && blit_busy);
			channel_enable   <= dma_ctrl[PLANE_ENABLE_BIT:0] & {9{dma_ctrl[MASTER_ENABLE_BIT]}};
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_req_odd;
		mem_req |-> slot_odd && !slot_start;
	endproperty
	a_req_odd: assert property (p_req_odd) else $error("fetch outside odd slot");
	property p_danger;
		register_bus_valid && !$past(danger) |-> !in_blit_range({1'b0, register_bus_addr});
	endproperty
	a_danger: assert property (p_danger) else $error("blitter write without danger");
	property p_jump;
		apb_wr && apb_idx == IDX_JUMP_STROBE_ONE && !vblank_start |=>
			pc == $past(ptr_one) && state == ST_FETCH_FIRST && !pending;
	endproperty
	a_jump: assert property (p_jump) else $error("strobe did not jump");
	property p_vblank;
		vblank_start |=> pc == $past(ptr_one) ##1 !register_bus_valid || pc == $past(ptr_one, 2);
	endproperty
	a_vblank: assert property (p_vblank) else $error("blanking reload missing");
	property p_marker;
		ack_ok && state == ST_FETCH_FIRST && !jump_one && !jump_two |=> register_bus_valid &&
			register_bus_addr == IDX_FETCH_MARKER[8:0] && state == ST_FETCH_SECOND;
	endproperty
	a_marker: assert property (p_marker) else $error("fetch marker not driven");
	property p_wait_quiet;
		state == ST_BEAM_WAIT |=> !mem_req;
	endproperty
	a_wait_quiet: assert property (p_wait_quiet) else $error("bus used while waiting");
	property p_enable;
		!fetch_en |=> !mem_req && $stable(pc) || $past(jump_one) || $past(jump_two) || $past(ack_ok);
	endproperty
	a_enable: assert property (p_enable) else $error("fetch while disabled");
	property p_arb;
		mem_req |-> !blit_grant && !cpu_grant;
	endproperty
	a_arb: assert property (p_arb) else $error("grant during coprocessor slot");
	property p_steal;
		dma_ctrl[BLIT_PRIORITY_BIT] && blit_busy |=> !bus_steal_enable;
	endproperty
	a_steal: assert property (p_steal) else $error("bus steal left enabled");
	property p_dma_set;
		apb_wr && apb_idx == IDX_DMA_CONTROL_WRITE && pwdata[SET_OR_CLEAR_BIT] |=>
			(dma_ctrl & $past(wr_data[10:0])) == $past(wr_data[10:0]);
	endproperty
	a_dma_set: assert property (p_dma_set) else $error("set bits not set");
	property p_skip;
		ack_ok && skip_next && state == ST_FETCH_SECOND && is_move && !jump_one && !jump_two
			|=> !register_bus_valid;
	endproperty
	a_skip: assert property (p_skip) else $error("skipped move was written");

	c_wait:  cover property (state == ST_BEAM_WAIT ##[1:50] state == ST_FETCH_FIRST);
	c_skip:  cover property ($rose(skip_next));
	c_move:  cover property (register_bus_valid && register_bus_addr != IDX_FETCH_MARKER[8:0]);
	c_jump2: cover property (jump_two && pending);

endmodule

`default_nettype wire

// ### dlc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module dlc_mem_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Fetch port
	input  wire logic        mem_req,
	input  wire logic [17:0] mem_addr,
	output logic             mem_ack,
	output logic      [15:0] mem_rdata
);
	logic [15:0] words [int];
	logic [17:0] addr_q;
	int          wait_cnt;

	// Idle data flips every cycle so a stale word can never pass for an answer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack   <= 1'b0;
			mem_rdata <= 16'h0000;
			wait_cnt  <= 0;
		end else begin
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req) begin
				addr_q   <= mem_addr;
				wait_cnt <= $urandom_range(1, 8);
			end else if (wait_cnt == 1) begin
				mem_ack   <= 1'b1;
				mem_rdata <= words.exists(int'(addr_q)) ? words[int'(addr_q)] : 16'hdead;
				wait_cnt  <= 0;
			end else if (wait_cnt > 1) begin
				wait_cnt <= wait_cnt - 1;
			end
		end
	end
endmodule

`default_nettype wire

// ### dlc_pkg.sv
package dlc_pkg;

	// Timing
	localparam int unsigned CLK_NS         = 25;
	localparam int unsigned MEM_CYCLE_NS   = 280;
	localparam int unsigned MEM_CYCLE_CLKS = (MEM_CYCLE_NS + CLK_NS - 1) / CLK_NS;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_DMA_CONTROL_READ  = 10'h002;
	localparam logic [9:0] IDX_COPROC_CONTROL    = 10'h02e;
	localparam logic [9:0] IDX_JUMP_PTR_ONE_HIGH = 10'h080;
	localparam logic [9:0] IDX_JUMP_PTR_ONE_LOW  = 10'h082;
	localparam logic [9:0] IDX_JUMP_PTR_TWO_HIGH = 10'h084;
	localparam logic [9:0] IDX_JUMP_PTR_TWO_LOW  = 10'h086;
	localparam logic [9:0] IDX_JUMP_STROBE_ONE   = 10'h088;
	localparam logic [9:0] IDX_JUMP_STROBE_TWO   = 10'h08a;
	localparam logic [9:0] IDX_FETCH_MARKER      = 10'h08c;
	localparam logic [9:0] IDX_DMA_CONTROL_WRITE = 10'h096;
	localparam logic [9:0] IDX_BLIT_REG_FIRST    = 10'h040;
	localparam logic [9:0] IDX_BLIT_REG_LAST     = 10'h07e;

	// Pointer layout
	localparam int unsigned PTR_HI_BITS = 3;
	localparam int unsigned PTR_LO_BITS = 15;
	localparam int unsigned PTR_BITS    = PTR_HI_BITS + PTR_LO_BITS;

	// DMA control fields
	localparam int unsigned SET_OR_CLEAR_BIT   = 15;
	localparam int unsigned BLIT_ACTIVE_BIT    = 14;
	localparam int unsigned BLIT_ZERO_BIT      = 13;
	localparam int unsigned BLIT_PRIORITY_BIT  = 10;
	localparam int unsigned MASTER_ENABLE_BIT  = 9;
	localparam int unsigned PLANE_ENABLE_BIT   = 8;
	localparam int unsigned COPROC_ENABLE_BIT  = 7;
	localparam int unsigned BLIT_ENABLE_BIT    = 6;
	localparam logic [10:0] DMA_CONTROL_RESET  = 11'h000;

	// Coprocessor control and instruction fields
	localparam int unsigned DANGER_MODE_BIT    = 1;
	localparam logic        DANGER_MODE_RESET  = 1'b0;
	localparam int unsigned INSTR_CLASS_BIT    = 0;
	localparam int unsigned BLIT_DONE_IGN_BIT  = 15;

	typedef enum logic [2:0] {
		ST_FETCH_FIRST  = 3'b001,
		ST_FETCH_SECOND = 3'b010,
		ST_BEAM_WAIT    = 3'b100
	} dlc_state_t;

endpackage

// ### tb_display_list_coprocessor.sv
`timescale 1ns/1ps
`default_nettype none

module tb_display_list_coprocessor;
	import dlc_pkg::*;

	typedef struct {logic [8:0] addr; logic [15:0] data; bit any;} dlc_exp_t;

	localparam int P1 = 'h28010;
	localparam int P2 = 'h10040;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, mem_req, mem_ack, register_bus_valid;
	logic [17:0] mem_addr;
	logic [15:0] mem_rdata, register_bus_data;
	logic [8:0]  register_bus_addr, channel_enable;
	logic [8:0]  beam_row = 9'h000;
	logic [8:0]  beam_col = 9'h000;
	logic        vblank_start = 1'b0;
	logic        blit_done = 1'b0;
	logic        blit_busy = 1'b0;
	logic        blit_zero = 1'b0;
	logic        blit_req = 1'b0;
	logic        cpu_req = 1'b0;
	logic        blit_grant, cpu_grant, bus_steal_enable;
	dlc_exp_t    expq [$];
	dlc_exp_t    e;
	int          bad_count = 0;
	int          checked = 0;
	int          seen = 0;

	dlc_display_list_coprocessor dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.register_bus_valid(register_bus_valid), .register_bus_addr(register_bus_addr),
		.register_bus_data(register_bus_data),
		.beam_row(beam_row), .beam_col(beam_col), .vblank_start(vblank_start),
		.blit_done(blit_done), .blit_busy(blit_busy), .blit_zero(blit_zero),
		.blit_req(blit_req), .cpu_req(cpu_req), .blit_grant(blit_grant), .cpu_grant(cpu_grant),
		.bus_steal_enable(bus_steal_enable), .channel_enable(channel_enable)
	);

	dlc_mem_model mem (
		.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata)
	);

	always #12.5 pclk = ~pclk;

	// Beam row stays below 128 so the unmaskable top row bit decides the final wait
	always @(posedge pclk) begin
		beam_row <= 9'($urandom_range(0, 127));
		beam_col <= 9'($urandom);
		blit_req <= 1'($urandom);
		cpu_req  <= 1'($urandom);
	end

	task automatic print_verdict();
		if (bad_count == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic fail(input string m);
		bad_count++;
		$display("MISMATCH %0t %s", $time, m);
	endtask

	task automatic check(input logic [31:0] g, input logic [31:0] x, input string m);
		checked++;
		if (g !== x) fail(m);
	endtask

	always @(posedge pclk) begin
		if (mem_req === 1'b1) begin
			check({30'h0, blit_grant, cpu_grant}, 32'h0, "grant in fetch slot");
		end
		if (register_bus_valid === 1'b1) begin
			seen++;
			if (expq.size() == 0) fail("unexpected register bus write");
			else begin
				e = expq.pop_front();
				check(32'(register_bus_addr), 32'(e.addr), "bus address");
				if (!e.any) check(32'(register_bus_data), 32'(e.data), "move data");
			end
		end
	end

	task automatic apb(input logic w, input logic [9:0] idx, input logic [15:0] d,
			output logic [31:0] r, output logic err);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {16'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fail("no bus answer");
		r = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [15:0] d);
		logic [31:0] r;
		logic        err;
		apb(1'b1, idx, d, r, err);
	endtask

	task automatic rd(input logic [9:0] idx, input logic [31:0] x, input logic xerr);
		logic [31:0] r;
		logic        err;
		apb(1'b0, idx, 16'h0, r, err);
		check({31'h0, err}, {31'h0, xerr}, "slave error");
		if (!xerr) check(r, x, "read data");
	endtask

	// Mode 0 none, 1 fetch marker, 2 move target for the second word
	task automatic ins(input int a, input logic [15:0] w1, input logic [15:0] w2, input int m);
		mem.words[a] = w1;
		mem.words[a + 1] = w2;
		expq.push_back('{9'h08c, 16'h0, 1'b1});
		if (m == 1) expq.push_back('{9'h08c, 16'h0, 1'b1});
		if (m == 2) expq.push_back('{w1[8:0] & 9'h1fe, w2, 1'b0});
	endtask

	task automatic load(input bit danger);
		ins(P1, 16'h0180, 16'h0abc, 2);
		ins(P1 + 2, 16'h0040, 16'h1234, danger ? 2 : 0);
		ins(P1 + 4, 16'h0001, 16'h8001, 1);
		ins(P1 + 6, 16'h0182, 16'h5555, 0);
		ins(P1 + 8, 16'h0001, 16'h0000, 1);
		ins(P1 + 10, 16'h008a, 16'h0000, 2);
		ins(P2, 16'h0184, 16'($urandom), 2);
		ins(P2 + 2, 16'hff01, 16'h0000, 1);
	endtask

	task automatic wait_seen(input int n);
		for (int i = 0; i < 3000 && seen < n; i++) @(posedge pclk);
		check(seen, n, "register bus write count");
	endtask

	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge pclk);
			if (mem_req === 1'b1) fail("fetch while it must hold off");
		end
	endtask

	initial begin
		repeat (40000) @(posedge pclk);
		fail("timeout");
		print_verdict();
	end

	initial begin
		void'($urandom(43464));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		blit_busy <= 1'b1;
		rd(IDX_DMA_CONTROL_READ, 32'h4000, 1'b0);
		wr(IDX_DMA_CONTROL_READ, 16'hffff);
		wr(IDX_DMA_CONTROL_WRITE, 16'he000);
		rd(IDX_DMA_CONTROL_READ, 32'h4000, 1'b0);
		wr(IDX_DMA_CONTROL_WRITE, 16'h8740);
		rd(IDX_DMA_CONTROL_READ, 32'h4740, 1'b0);
		repeat (30) @(posedge pclk);
		check({23'h0, channel_enable}, 32'h140, "channel enables");
		check({31'h0, bus_steal_enable}, 32'h0, "bus steal");
		wr(IDX_DMA_CONTROL_WRITE, 16'h0500);
		rd(IDX_DMA_CONTROL_READ, 32'h4240, 1'b0);
		blit_busy <= 1'b0;
		repeat (30) @(posedge pclk);
		check({23'h0, channel_enable}, 32'h040, "channel enables");
		check({31'h0, bus_steal_enable}, 32'h1, "bus steal");
		rd(10'h3ff, 32'h0, 1'b1);
		rd(IDX_JUMP_PTR_ONE_LOW, 32'h0, 1'b0);
		wr(IDX_JUMP_PTR_ONE_HIGH, 16'h0005);
		wr(IDX_JUMP_PTR_ONE_LOW, 16'h0010);
		wr(IDX_JUMP_PTR_TWO_HIGH, 16'h0002);
		wr(IDX_JUMP_PTR_TWO_LOW, 16'h0040);
		wr(IDX_JUMP_STROBE_ONE, 16'h0000);
		load(1'b0);
		wr(IDX_DMA_CONTROL_WRITE, 16'h8080);
		wait_seen(8);
		quiet(100);
		blit_done <= 1'b1;
		wait_seen(14);
		quiet(100);
		wr(IDX_DMA_CONTROL_WRITE, 16'h0080);
		@(posedge pclk);
		vblank_start <= 1'b1;
		@(posedge pclk);
		vblank_start <= 1'b0;
		quiet(60);
		wr(IDX_COPROC_CONTROL, 16'h0002);
		load(1'b1);
		wr(IDX_DMA_CONTROL_WRITE, 16'h8080);
		wait_seen(29);
		quiet(50);
		check(expq.size(), 0, "writes left over");
		print_verdict();
	end
endmodule

`default_nettype wire
